// file: hw/csil_regs.vh
// Constants for the coupler status indicator logic
// Behaviour
// - Backplane link LED dark without link, lit when linked, blinking with traffic.
// - Downstream port LED dark when unattached, lit when linked, blinking with traffic.
// - Each green supply LED lit exactly while its supply-present input is high.
// - Red actuator fault LED lit on undervoltage or overload flag, else off.
// - Red system/sensor fault LED lit on undervoltage or overload flag, else off.
// - Run LED off in INIT, steadily on in OP.
// - Run LED blinks uniformly in PREOP.
// - Run LED blinks slowly in SAFEOP; outputs held safe there.
// - Run LED blinks rapidly in BOOTSTRAP.
// - After reset the description is loaded from nonvolatile store, giving configuration.
// - Stored data reachable both by mailbox transfers and by direct registers.
// - Written description or firmware words are accepted without content checks.
// - Bundled image, accepted in BOOT only, updates description only with password 1; program always.
// - State reported as 0x1 INIT, 0x2 PREOP, 0x3 BOOT, 0x4 SAFEOP, 0x8 OP.
`ifndef CSIL_REGS_VH
`define CSIL_REGS_VH
// Register byte offsets
`define CSIL_OFF_STATE 8'h00
`define CSIL_OFF_STATUS 8'h04
`define CSIL_OFF_FWCTRL 8'h08
`define CSIL_OFF_FWDATA 8'h0C
`define CSIL_OFF_FWDESC 8'h10
`define CSIL_OFF_MBXDATA 8'h14
`define CSIL_OFF_MBXCMD 8'h18
`define CSIL_OFF_DESC 8'h40
// Description window size
`define CSIL_DESC_WORDS 16
`define CSIL_DESC_AW 4
`define CSIL_DESC_LAST 4'hF
// State codes
`define CSIL_ST_INIT 4'h1
`define CSIL_ST_PREOP 4'h2
`define CSIL_ST_BOOT 4'h3
`define CSIL_ST_SAFEOP 4'h4
`define CSIL_ST_OP 4'h8
// Field positions
`define CSIL_FW_PASSWORD 0
`define CSIL_MBX_WRITE 4
`define CSIL_MBX_READ 5
`define CSIL_CFG_BITS 7:0
// Timing: one blink tick, and half periods in ticks
`define CSIL_CLK_HZ 25000000
`define CSIL_TICK_US 1000
`define CSIL_RAPID_HALF 16'd0050
`define CSIL_UNIFORM_HALF 16'd0200
`define CSIL_SLOW_HALF 16'd0500
`define CSIL_ACT_HOLD 16'd0100
// AHB constants
`define CSIL_HTRANS_NONSEQ 2'b10
`define CSIL_HRESP_OKAY 1'b0
`endif

// file: hw/csil_blink_gen.v
// Blink pattern generator with shared prescaler
`timescale 1ns/1ps
`default_nettype none
`include "csil_regs.vh"
module csil_blink_gen #(
  parameter TICK_CYCLES = 25000
) (
  input wire core_clk,
  input wire rstn,
  output reg tickPulse,
  output reg rapidPhase,
  output reg uniformPhase,
  output reg slowPhase
);
  reg [31:0] preCnt_reg;
  reg [15:0] rapidCnt_reg;
  reg [15:0] uniformCnt_reg;
  reg [15:0] slowCnt_reg;

  // Half-period reached test
  function done;
    input [15:0] cnt;
    input [15:0] half;
    begin
      done = (cnt == half - 16'h0001);
    end
  endfunction

  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      preCnt_reg <= 32'h0000_0000;
      tickPulse <= 1'b0;
      rapidCnt_reg <= 16'h0000;
      uniformCnt_reg <= 16'h0000;
      slowCnt_reg <= 16'h0000;
      rapidPhase <= 1'b0;
      uniformPhase <= 1'b0;
      slowPhase <= 1'b0;
    end
    else
    begin
      tickPulse <= 1'b0;
      if (preCnt_reg == TICK_CYCLES - 1)
      begin
        preCnt_reg <= 32'h0000_0000;
        tickPulse <= 1'b1;
        rapidCnt_reg <= done(rapidCnt_reg, `CSIL_RAPID_HALF) ? 16'h0000 : rapidCnt_reg + 16'h0001;
        uniformCnt_reg <= done(uniformCnt_reg, `CSIL_UNIFORM_HALF) ? 16'h0000 : uniformCnt_reg + 16'h0001;
        slowCnt_reg <= done(slowCnt_reg, `CSIL_SLOW_HALF) ? 16'h0000 : slowCnt_reg + 16'h0001;
        if (done(rapidCnt_reg, `CSIL_RAPID_HALF))
          rapidPhase <= ~rapidPhase;
        if (done(uniformCnt_reg, `CSIL_UNIFORM_HALF))
          uniformPhase <= ~uniformPhase;
        if (done(slowCnt_reg, `CSIL_SLOW_HALF))
          slowPhase <= ~slowPhase;
      end
      else
        preCnt_reg <= preCnt_reg + 32'h0000_0001;
    end
  end
endmodule // csil_blink_gen
`default_nettype wire

// file: hw/csil_status_top.v
// Coupler status indicators, state reporting and update acceptance
`timescale 1ns/1ps
`default_nettype none
`include "csil_regs.vh"
module csil_status_top #(
  parameter TICK_CYCLES = (`CSIL_CLK_HZ / 1000000) * `CSIL_TICK_US
) (
  input wire core_clk,
  input wire rstn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Link and supply pins
  input wire backplaneLink,
  input wire backplaneActivity,
  input wire downstreamLink,
  input wire downstreamActivity,
  input wire systemSupplyPresent,
  input wire actuatorSupplyPresent,
  input wire systemSupplyLow,
  input wire systemSupplyOverload,
  input wire actuatorSupplyLow,
  input wire actuatorSupplyOverload,
  // Nonvolatile description store
  output reg nvmRead,
  output reg nvmWrite,
  output reg [3:0] nvmAddr,
  output reg [31:0] nvmWdata,
  input wire [31:0] nvmRdata,
  // Program store
  output reg fwWrite,
  output reg [31:0] fwWdata,
  // Indicators and control
  output reg backplane_link_activity_led,
  output reg downstream_link_activity_led,
  output reg system_supply_present_led,
  output reg actuator_supply_present_led,
  output reg system_supply_fault_led,
  output reg actuator_supply_fault_led,
  output reg run_led,
  output reg outputsSafe,
  output reg [7:0] commConfig
);
  localparam LD_READ = 3'b001;
  localparam LD_LAST = 3'b010;
  localparam LD_DONE = 3'b100;
  reg [9:0] syncA_reg, syncB_reg;
  reg [15:0] bpHold_reg, dsHold_reg;
  reg [2:0] ld_reg;
  reg [3:0] ldIdx_reg, ldCapIdx_reg, state_reg, fwDescIdx_reg;
  reg ldValid_reg, password_reg, dWrite_reg;
  reg [31:0] descMem [0:`CSIL_DESC_WORDS-1];
  reg [31:0] mbxData_reg;
  reg [7:0] dAddr_reg;
  wire tickPulse, rapidPhase, uniformPhase, slowPhase;
  wire addrPhase, loadDone;
  wire [7:0] aOff;
  reg [31:0] rdNext, descWd;
  reg descWe;
  reg [3:0] descWa, stateNext;
  // Synchronised pin views
  wire bpLinkS = syncB_reg[0], bpActS = syncB_reg[1];
  wire dsLinkS = syncB_reg[2], dsActS = syncB_reg[3];
  wire sysPresS = syncB_reg[4], actPresS = syncB_reg[5];
  wire sysLowS = syncB_reg[6], sysOvlS = syncB_reg[7];
  wire actLowS = syncB_reg[8], actOvlS = syncB_reg[9];
  // Shared blink phases and tick
  csil_blink_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) blinkGen (
    .core_clk(core_clk),
    .rstn(rstn),
    .tickPulse(tickPulse),
    .rapidPhase(rapidPhase),
    .uniformPhase(uniformPhase),
    .slowPhase(slowPhase)
  );
  // Address phase decode and load status
  assign addrPhase = hsel & hready & (htrans == `CSIL_HTRANS_NONSEQ);
  assign aOff = haddr[7:0];
  assign loadDone = (ld_reg == LD_DONE);
  // Descriptor window hit test
  function inDesc;
    input [7:0] off;
    begin
      inDesc = (off[7:6] == `CSIL_OFF_DESC >> 6) && (off[1:0] == 2'b00);
    end
  endfunction
  // Legal state request check
  function [3:0] nextState;
    input [3:0] cur;
    input [3:0] req;
    begin
      nextState = cur;
      case (req)
        `CSIL_ST_INIT: nextState = req;
        `CSIL_ST_BOOT: if (cur == `CSIL_ST_INIT) nextState = req;
        `CSIL_ST_PREOP, `CSIL_ST_SAFEOP, `CSIL_ST_OP: if (cur != `CSIL_ST_BOOT) nextState = req;
        default: nextState = cur;
      endcase
    end
  endfunction
  // Two-stage pin synchronisers
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      syncA_reg <= 10'h000;
      syncB_reg <= 10'h000;
    end
    else
    begin
      syncA_reg <= {actuatorSupplyOverload, actuatorSupplyLow, systemSupplyOverload, systemSupplyLow,
        actuatorSupplyPresent, systemSupplyPresent, downstreamActivity, downstreamLink,
        backplaneActivity, backplaneLink};
      syncB_reg <= syncA_reg;
    end
  end
  // Traffic seen recently, held for a number of ticks
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      bpHold_reg <= 16'h0000;
      dsHold_reg <= 16'h0000;
    end
    else
    begin
      if (bpActS)
        bpHold_reg <= `CSIL_ACT_HOLD;
      else if (tickPulse && bpHold_reg != 16'h0000)
        bpHold_reg <= bpHold_reg - 16'h0001;
      if (dsActS)
        dsHold_reg <= `CSIL_ACT_HOLD;
      else if (tickPulse && dsHold_reg != 16'h0000)
        dsHold_reg <= dsHold_reg - 16'h0001;
    end
  end
  // Indicator drivers
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      backplane_link_activity_led <= 1'b0;
      downstream_link_activity_led <= 1'b0;
      system_supply_present_led <= 1'b0;
      actuator_supply_present_led <= 1'b0;
      system_supply_fault_led <= 1'b0;
      actuator_supply_fault_led <= 1'b0;
      run_led <= 1'b0;
      outputsSafe <= 1'b1;
    end
    else
    begin
      backplane_link_activity_led <= bpLinkS & ((bpHold_reg == 16'h0000) | rapidPhase);
      downstream_link_activity_led <= dsLinkS & ((dsHold_reg == 16'h0000) | rapidPhase);
      system_supply_present_led <= sysPresS;
      actuator_supply_present_led <= actPresS;
      actuator_supply_fault_led <= actLowS | actOvlS;
      system_supply_fault_led <= sysLowS | sysOvlS;
      outputsSafe <= (state_reg != `CSIL_ST_OP);
      case (state_reg)
        `CSIL_ST_INIT: run_led <= 1'b0;
        `CSIL_ST_PREOP: run_led <= uniformPhase;
        `CSIL_ST_SAFEOP: run_led <= slowPhase;
        `CSIL_ST_BOOT: run_led <= rapidPhase;
        `CSIL_ST_OP: run_led <= 1'b1;
        default: run_led <= 1'b0;
      endcase
    end
  end
  // Bus write decode, all three update paths into the description
  always @*
  begin
    descWe = 1'b0;
    descWa = 4'h0;
    descWd = hwdata;
    stateNext = state_reg;
    if (dWrite_reg && loadDone)
    begin
      if (inDesc(dAddr_reg))
      begin
        descWe = 1'b1;
        descWa = dAddr_reg[5:2];
      end
      else if (dAddr_reg == `CSIL_OFF_MBXCMD && hwdata[`CSIL_MBX_WRITE])
      begin
        descWe = 1'b1;
        descWa = hwdata[3:0];
        descWd = mbxData_reg;
      end
      else if (dAddr_reg == `CSIL_OFF_FWDESC && state_reg == `CSIL_ST_BOOT && password_reg)
      begin
        descWe = 1'b1;
        descWa = fwDescIdx_reg;
      end
      if (dAddr_reg == `CSIL_OFF_STATE)
        stateNext = nextState(state_reg, hwdata[3:0]);
    end
  end
  // Power-up load, state, control registers and store writes
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ld_reg <= LD_READ;
      ldIdx_reg <= 4'h0;
      ldValid_reg <= 1'b0;
      ldCapIdx_reg <= 4'h0;
      state_reg <= `CSIL_ST_INIT;
      password_reg <= 1'b0;
      fwDescIdx_reg <= 4'h0;
      mbxData_reg <= 32'h0000_0000;
      nvmRead <= 1'b0;
      nvmWrite <= 1'b0;
      nvmAddr <= 4'h0;
      nvmWdata <= 32'h0000_0000;
      fwWrite <= 1'b0;
      fwWdata <= 32'h0000_0000;
      commConfig <= 8'h00;
    end
    else
    begin
      nvmRead <= 1'b0;
      nvmWrite <= 1'b0;
      fwWrite <= 1'b0;
      ldValid_reg <= 1'b0;
      case (ld_reg)
        LD_READ:
        begin
          nvmRead <= 1'b1;
          nvmAddr <= ldIdx_reg;
          ldValid_reg <= 1'b1;
          ldCapIdx_reg <= ldIdx_reg;
          ldIdx_reg <= ldIdx_reg + 4'h1;
          if (ldIdx_reg == `CSIL_DESC_LAST)
            ld_reg <= LD_LAST;
        end
        LD_LAST: ld_reg <= LD_DONE;
        LD_DONE: ld_reg <= LD_DONE;
        default: ld_reg <= LD_READ;
      endcase
      if (ldValid_reg && ldCapIdx_reg == 4'h0)
        commConfig <= nvmRdata[`CSIL_CFG_BITS];
      state_reg <= stateNext;
      // accepted writes go straight to the store
      if (descWe)
      begin
        nvmWrite <= 1'b1;
        nvmAddr <= descWa;
        nvmWdata <= descWd;
      end
      if (dWrite_reg && loadDone)
      begin
        case (dAddr_reg)
          `CSIL_OFF_FWCTRL:
          begin
            password_reg <= hwdata[`CSIL_FW_PASSWORD];
            fwDescIdx_reg <= 4'h0;
          end
          `CSIL_OFF_FWDATA:
          begin
            if (state_reg == `CSIL_ST_BOOT)
            begin
              fwWrite <= 1'b1;
              fwWdata <= hwdata;
            end
          end
          `CSIL_OFF_FWDESC:
          begin
            if (state_reg == `CSIL_ST_BOOT && password_reg)
              fwDescIdx_reg <= fwDescIdx_reg + 4'h1;
          end
          `CSIL_OFF_MBXDATA: mbxData_reg <= hwdata;
          `CSIL_OFF_MBXCMD:
          begin
            if (hwdata[`CSIL_MBX_READ] && !hwdata[`CSIL_MBX_WRITE])
              mbxData_reg <= descMem[hwdata[3:0]];
          end
          default: mbxData_reg <= mbxData_reg;
        endcase
      end
    end
  end
  // Description memory
  always @(posedge core_clk)
  begin
    if (ldValid_reg)
      descMem[ldCapIdx_reg] <= nvmRdata;
    else if (descWe)
      descMem[descWa] <= descWd;
  end
  // Read data for the address phase
  always @*
  begin
    rdNext = 32'h0000_0000;
    if (inDesc(aOff))
      rdNext = descMem[aOff[5:2]];
    else
    begin
      case (aOff)
        `CSIL_OFF_STATE: rdNext = {28'h000_0000, state_reg};
        `CSIL_OFF_STATUS: rdNext = {20'h0_0000, outputsSafe, run_led, actuator_supply_fault_led,
          system_supply_fault_led, actuator_supply_present_led, system_supply_present_led,
          downstream_link_activity_led, backplane_link_activity_led, 3'b000, loadDone};
        `CSIL_OFF_FWCTRL: rdNext = {31'h0000_0000, password_reg};
        `CSIL_OFF_MBXDATA: rdNext = mbxData_reg;
        default: rdNext = 32'h0000_0000;
      endcase
    end
  end
  // AHB-Lite slave, zero wait, always OKAY
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      dWrite_reg <= 1'b0;
      dAddr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= `CSIL_HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= `CSIL_HRESP_OKAY;
      if (hready)
      begin
        dWrite_reg <= addrPhase & hwrite;
        dAddr_reg <= aOff;
        if (addrPhase && !hwrite)
          hrdata <= rdNext;
      end
    end
  end
endmodule // csil_status_top
`default_nettype wire

// file: tb/csil_nvm_model.sv
// Model of the nonvolatile description store
`timescale 1ns/1ps
`default_nettype none
module csil_nvm_model #(
  parameter logic [31:0] BASE = 32'h5A3C_0100
) (
  input wire logic core_clk,
  input wire logic nvmRead,
  input wire logic nvmWrite,
  input wire logic [3:0] nvmAddr,
  input wire logic [31:0] nvmWdata,
  output logic [31:0] nvmRdata
);
  logic [31:0] mem [0:15];
  // Known preload pattern
  initial
  begin
    for (int i = 0; i < 16; i++) mem[i] = BASE + 32'(i);
  end
  always @(posedge core_clk)
  begin
    if (nvmWrite) mem[nvmAddr] <= nvmWdata;
  end
  // word stands while the read strobe is high, inverse otherwise
  assign nvmRdata = nvmRead ? mem[nvmAddr] : ~mem[nvmAddr];
endmodule // csil_nvm_model
`default_nettype wire

// file: tb/csil_status_sva.sv
// Checker for indicator timing, load start and bus answers
`timescale 1ns/1ps
`default_nettype none
module csil_status_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic backplaneLink,
  input wire logic downstreamLink,
  input wire logic systemSupplyPresent,
  input wire logic actuatorSupplyPresent,
  input wire logic systemSupplyLow,
  input wire logic systemSupplyOverload,
  input wire logic actuatorSupplyLow,
  input wire logic actuatorSupplyOverload,
  input wire logic nvmRead,
  input wire logic [3:0] nvmAddr,
  input wire logic backplane_link_activity_led,
  input wire logic downstream_link_activity_led,
  input wire logic system_supply_present_led,
  input wire logic actuator_supply_present_led,
  input wire logic system_supply_fault_led,
  input wire logic actuator_supply_fault_led,
  input wire logic run_led,
  input wire logic outputsSafe
);
  logic [4:0] rstAge;
  wire logic warm;
  // Edges since reset release
  always @(posedge core_clk)
  begin
    if (!rstn) rstAge <= 5'h00;
    else if (rstAge != 5'h1F) rstAge <= rstAge + 5'h01;
  end
  assign warm = rstAge >= 5'h04;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_op_held;
    (!outputsSafe) [*3];
  endsequence
  sequence s_load_first;
    nvmRead && nvmAddr == 4'h0;
  endsequence
  a_sys_present: assert property (
    warm |-> system_supply_present_led == $past(systemSupplyPresent, 3)) else $error("sys present led");
  a_act_present: assert property (
    warm |-> actuator_supply_present_led == $past(actuatorSupplyPresent, 3)) else $error("act present led");
  a_act_fault: assert property (
    warm |-> actuator_supply_fault_led == $past(actuatorSupplyLow || actuatorSupplyOverload, 3))
    else $error("act fault led");
  a_sys_fault: assert property (
    warm |-> system_supply_fault_led == $past(systemSupplyLow || systemSupplyOverload, 3))
    else $error("sys fault led");
  a_run_op_on: assert property (s_op_held |-> run_led) else $error("run led off in op");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
  a_bp_dark: assert property (
    warm && !$past(backplaneLink, 3) |-> !backplane_link_activity_led) else $error("bp led lit");
  a_ds_dark: assert property (
    warm && !$past(downstreamLink, 3) |-> !downstream_link_activity_led) else $error("ds led lit");
  a_load_start: assert property ((rstAge == 5'h01) |-> ##[0:2] s_load_first) else $error("no load");
  a_load_walk: assert property (
    (rstAge < 5'h14 && nvmRead && nvmAddr == 4'h0) |=> (nvmRead && nvmAddr == 4'h1)) else $error("load order");
endmodule // csil_status_sva
bind csil_status_top csil_status_sva u_sva (.core_clk, .rstn, .hreadyout, .hresp, .backplaneLink,
  .downstreamLink, .systemSupplyPresent, .actuatorSupplyPresent, .systemSupplyLow, .systemSupplyOverload,
  .actuatorSupplyLow, .actuatorSupplyOverload, .nvmRead, .nvmAddr, .backplane_link_activity_led,
  .downstream_link_activity_led, .system_supply_present_led, .actuator_supply_present_led,
  .system_supply_fault_led, .actuator_supply_fault_led, .run_led, .outputsSafe);
`default_nettype wire

// file: tb/csil_status_top_tb.sv
// Self-checking bench for the status indicator block
`timescale 1ns/1ps
`default_nettype none
`include "csil_regs.vh"
module csil_status_top_tb;
  localparam int TICK = 4;
  localparam logic [31:0] BASE = 32'h5A3C_01A5;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [5:0] pins = 6'h00; // sysPres actPres sysLow sysOvl actLow actOvl
  logic [1:0] links = 2'h0;
  logic [1:0] acts = 2'h0;
  wire logic hready, hreadyout, hresp, nvmRead, nvmWrite, fwWrite, outputsSafe;
  wire logic [3:0] nvmAddr;
  wire logic [31:0] hrdata, nvmWdata, nvmRdata, fwWdata;
  wire logic [6:0] leds; // bp ds sysPres actPres sysFault actFault run
  wire logic [7:0] commConfig;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int fwCount = 0;
  int nvmCount = 0;
  logic [31:0] lastFw;
  logic [31:0] rd;
  // Clock and single slave ready
  always #20 core_clk = ~core_clk;
  assign hready = hreadyout;
  csil_status_top #(.TICK_CYCLES(TICK)) u_dut (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .backplaneLink(links[0]),
    .backplaneActivity(acts[0]), .downstreamLink(links[1]), .downstreamActivity(acts[1]),
    .systemSupplyPresent(pins[0]), .actuatorSupplyPresent(pins[1]), .systemSupplyLow(pins[2]),
    .systemSupplyOverload(pins[3]), .actuatorSupplyLow(pins[4]), .actuatorSupplyOverload(pins[5]),
    .nvmRead, .nvmWrite, .nvmAddr, .nvmWdata, .nvmRdata, .fwWrite, .fwWdata,
    .backplane_link_activity_led(leds[0]), .downstream_link_activity_led(leds[1]),
    .system_supply_present_led(leds[2]), .actuator_supply_present_led(leds[3]),
    .system_supply_fault_led(leds[4]), .actuator_supply_fault_led(leds[5]), .run_led(leds[6]),
    .outputsSafe, .commConfig);
  csil_nvm_model #(.BASE(BASE)) u_nvm (.core_clk, .nvmRead, .nvmWrite, .nvmAddr, .nvmWdata, .nvmRdata);
  // Strobe monitors and hang guard
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (fwWrite === 1'b1)
    begin
      fwCount <= fwCount + 1;
      lastFw <= fwWdata;
    end
    if (nvmWrite === 1'b1) nvmCount <= nvmCount + 1;
    if (cycles == 40000)
    begin
      n_errors++;
      close_out;
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One single transfer; read data lands in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= `CSIL_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Three toggles of one LED; last gap must be h cycles, first may be pattern onset
  task half(input int h, input int k);
    int n;
    logic v;
    repeat (3)
    begin
      v = leds[k];
      n = 0;
      while (leds[k] === v && n < 3 * h)
      begin
        @(posedge core_clk);
        n++;
      end
    end
    check(32'(n), 32'(h));
  endtask
  task go(input logic [3:0] c);
    bus(1'b1, `CSIL_OFF_STATE, {28'h000_0000, c});
    bus(1'b0, `CSIL_OFF_STATE, 32'h0000_0000);
    check(rd, {28'h000_0000, c});
  endtask
  task t_reset;
    bus(1'b0, `CSIL_OFF_STATE, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    bus(1'b0, `CSIL_OFF_STATUS, 32'h0000_0000);
    check(rd[0], 1'b0);
    repeat (30) if (rd[0] !== 1'b1) bus(1'b0, `CSIL_OFF_STATUS, 32'h0000_0000);
    check(rd[0], 1'b1);
    check(commConfig, BASE[7:0]);
    for (int i = 0; i < 16; i++)
    begin
      bus(1'b0, `CSIL_OFF_DESC + 8'(4 * i), 32'h0000_0000);
      check(rd, BASE + 32'(i));
    end
    bus(1'b0, 8'h30, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("done: reset and load");
  endtask
  task t_supply;
    logic [5:0] p;
    for (int i = 0; i < 64; i++)
    begin
      p = 6'(i);
      pins <= p;
      cyc(5);
      check(leds[5:2], {p[4] | p[5], p[2] | p[3], p[1], p[0]});
    end
    $display("done: supply");
  endtask
  task t_links;
    links <= 2'h3;
    cyc(`CSIL_ACT_HOLD * TICK + 10);
    check(leds[1:0], 2'h3);
    cyc(300);
    check(leds[1:0], 2'h3);
    acts <= 2'h3;
    half(`CSIL_RAPID_HALF * TICK, 0);
    half(`CSIL_RAPID_HALF * TICK, 1);
    acts <= 2'h0;
    links <= 2'h0;
    cyc(5);
    check(leds[1:0], 2'h0);
    $display("done: links");
  endtask
  task t_run;
    go(`CSIL_ST_PREOP);
    half(`CSIL_UNIFORM_HALF * TICK, 6);
    go(`CSIL_ST_SAFEOP);
    half(`CSIL_SLOW_HALF * TICK, 6);
    check(outputsSafe, 1'b1);
    go(`CSIL_ST_OP);
    cyc(4);
    check({outputsSafe, leds[6]}, 2'h1);
    go(`CSIL_ST_INIT);
    cyc(4);
    check(leds[6], 1'b0);
    go(`CSIL_ST_BOOT);
    half(`CSIL_RAPID_HALF * TICK, 6);
    $display("done: run patterns");
  endtask
  task t_update;
    bus(1'b1, `CSIL_OFF_FWCTRL, 32'h0000_0000);
    bus(1'b1, `CSIL_OFF_FWDATA, 32'h1234_5678);
    bus(1'b1, `CSIL_OFF_FWDESC, 32'hDEAD_0001);
    cyc(3);
    check(lastFw, 32'h1234_5678);
    check(32'(nvmCount), 32'h0000_0000);
    bus(1'b1, `CSIL_OFF_FWCTRL, 32'h0000_0001);
    bus(1'b1, `CSIL_OFF_FWDATA, 32'h0000_0002);
    bus(1'b1, `CSIL_OFF_FWDESC, 32'hC0DE_0001);
    cyc(3);
    check(32'(fwCount), 32'h0000_0002);
    check(32'(nvmCount), 32'h0000_0001);
    bus(1'b0, `CSIL_OFF_DESC, 32'h0000_0000);
    check(rd, 32'hC0DE_0001);
    bus(1'b1, `CSIL_OFF_STATE, 32'h0000_0008);
    bus(1'b0, `CSIL_OFF_STATE, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    go(`CSIL_ST_INIT);
    $display("done: update");
  endtask
  task t_mbx;
    bus(1'b1, `CSIL_OFF_MBXDATA, 32'h0BAD_F00D);
    bus(1'b1, `CSIL_OFF_MBXCMD, 32'h0000_0015);
    bus(1'b0, `CSIL_OFF_DESC + 8'h14, 32'h0000_0000);
    check(rd, 32'h0BAD_F00D);
    bus(1'b1, `CSIL_OFF_MBXDATA, 32'h0000_0000);
    bus(1'b1, `CSIL_OFF_MBXCMD, 32'h0000_0025);
    bus(1'b0, `CSIL_OFF_MBXDATA, 32'h0000_0000);
    check(rd, 32'h0BAD_F00D);
    bus(1'b1, `CSIL_OFF_DESC + 8'h08, 32'h7777_0002);
    bus(1'b0, `CSIL_OFF_DESC + 8'h08, 32'h0000_0000);
    check(rd, 32'h7777_0002);
    cyc(3);
    check(32'(nvmCount), 32'h0000_0003);
    check(u_nvm.mem[5], 32'h0BAD_F00D);
    $display("done: mailbox");
  endtask
  // Main sequence
  initial
  begin
    cyc(10);
    check({outputsSafe, leds}, 8'h80);
    rstn <= 1'b1;
    t_reset;
    t_supply;
    t_links;
    t_run;
    t_update;
    t_mbx;
    close_out;
  end
endmodule // csil_status_top_tb
`default_nettype wire
